// File: dv/sac_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_master_model (
    input wire logic clk,
    input wire logic dout_o,
    input wire logic dout_oe,
    output logic cs_n,
    output logic sclk
);
    // A released output reads as the inverse of its last value
    logic pin;
    assign pin = dout_oe ? dout_o : ~dout_o;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end
    task automatic convert(input int nbits, output logic [15:0] word, output int waited);
        word = 16'h0000;
        waited = 0;
        @(posedge clk);
        cs_n <= 1'b0;
        while (!(dout_oe && dout_o) && waited < 200) begin
            @(posedge clk);
            waited++;
        end
        for (int i = 0; i < nbits; i++) begin
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            word = {word[14:0], pin};
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        abort(4);
    endtask
    task automatic abort(input int n);
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (n) @(posedge clk);
        cs_n <= 1'b1;
        repeat (20) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: dv/sac_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sac_port_bench
    import sac_pkg::*;
;
    logic ref_clk, resetn, cs_n, sclk, pd_lvl, pd_drv, comp_in, dout_o, dout_oe;
    logic th_hold, shutdown, ref_internal, psel, penable, pwrite, pready, pslverr, err;
    logic [RES_BITS-1:0] dac_code, ain;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] word;
    int waited, fail_count, checks_done;
    int cyc = 0;
    sac_port dut_u (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
        .power_down_n_tristate_level(pd_lvl), .power_down_n_tristate_driven(pd_drv),
        .comp_in(comp_in), .dout_o(dout_o), .dout_oe(dout_oe), .th_hold(th_hold),
        .dac_code(dac_code), .shutdown(shutdown), .ref_internal(ref_internal),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sac_master_model model_u (.clk(ref_clk), .dout_o(dout_o), .dout_oe(dout_oe),
        .cs_n(cs_n), .sclk(sclk));
    always #50 ref_clk = ~ref_clk;
    // Comparator of an ideal unipolar input against the trial code
    always @(posedge ref_clk) comp_in <= (ain >= dac_code);
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    function automatic logic [15:0] frame(input logic [11:0] v);
        return {1'b1, v, 3'b000};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        {ref_clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ain, fail_count, checks_done} = '0;
        pd_lvl = 1'b1;
        pd_drv = 1'b1;
        void'($urandom(32'he07623e3));
        repeat (4) @(posedge ref_clk);
        check({dout_oe, th_hold, shutdown, pready}, 0);
        resetn <= 1'b1;
        // bypass charging is analogue only; the model starts early
        repeat (30) @(posedge ref_clk);
        apb(0, REG_CTRL, 0);
        check(err, 0);
        check(rd, {31'h0, CTRL_RESET});
        apb(1, 8'h40, 32'hffffffff);
        check(err, 1);
        apb(0, 8'h40, 0);
        check(err, 1);
        check(rd, 0);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            ain <= (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            if (i == 6) model_u.abort(20);
            model_u.convert(16, word, waited);
            check(word, frame(ain));
            check(waited inside {[85:92]}, 1);
            apb(0, REG_RESULT, 0);
            check(rd, {20'h0, ain});
            check(dac_code, ain);
        end
        apb(0, REG_COUNT, 0);
        check(rd, 7);
        $display("test conversions done");
        pd_lvl <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check(shutdown, 1);
        fork
            model_u.abort(10);
            begin
                repeat (8) @(posedge ref_clk);
                check({dout_oe, dout_o, th_hold}, 3'b100);
            end
        join
        pd_lvl <= 1'b1;
        repeat (25) @(posedge ref_clk);
        check({shutdown, ref_internal}, 2'b01);
        pd_drv <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({shutdown, ref_internal}, 2'b00);
        apb(1, REG_CTRL, 1);
        apb(0, REG_CTRL, 0);
        check(shutdown, 1);
        check(rd, 1);
        apb(0, REG_STATUS, 0);
        check(rd, 32'ha8);
        apb(1, REG_CTRL, 0);
        // wake delay before the next conversion
        repeat (25) @(posedge ref_clk);
        apb(0, REG_STATUS, 0);
        check(rd, 32'he0);
        model_u.convert(16, word, waited);
        check(word, frame(ain));
        check(waited inside {[85:92]}, 1);
        $display("test shutdown done");
        end_sim();
    end
endmodule
`default_nettype wire

// File: dv/sac_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sac_port_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic power_down_n_tristate_level,
    input wire logic power_down_n_tristate_driven,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic th_hold,
    input wire logic shutdown,
    input wire logic ref_internal
);
    logic [7:0] hold_cnt, age;
    logic [4:0] hi_cnt;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    // Hold length, cycles since a shift clock fall, idle select time
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt <= 8'h00;
            age <= 8'hff;
            hi_cnt <= 5'h00;
        end else begin
            hold_cnt <= th_hold ? hold_cnt + 8'h01 : 8'h00;
            age <= $fell(sclk) ? 8'h00 : age + {7'h00, age != 8'hff};
            hi_cnt <= (cs_n && !shutdown) ? hi_cnt + {4'h0, hi_cnt != 5'h1f} : 5'h00;
        end
    end
    sequence s_sel_fall;
        $fell(cs_n) && hi_cnt > 5'd19 ##1 !cs_n [*4];
    endsequence
    a_start_hold: assert property (s_sel_fall |-> th_hold && dout_oe && !dout_o)
        else $error("select fall did not start a conversion");
    a_conv_len: assert property ($fell(th_hold) && !cs_n |->
        dout_o && dout_oe && hold_cnt inside {[8'd84:8'd87]})
        else $error("conversion length or end flag wrong");
    a_no_early: assert property (th_hold && hold_cnt < 8'd80 |-> !dout_o)
        else $error("end flag too early");
    a_shift_edge: assert property (dout_oe && $past(dout_oe) && $changed(dout_o)
        && !$fell(th_hold) && !cs_n |-> age < 8'd6)
        else $error("output bit changed without shift clock fall");
    a_idle_off: assert property (cs_n [*5] |-> !dout_oe && !th_hold)
        else $error("output driven while deselected");
    a_pin_shut: assert property (
        (power_down_n_tristate_driven && !power_down_n_tristate_level) [*5] |-> shutdown)
        else $error("low pin did not shut down");
    a_ref_int: assert property (
        (power_down_n_tristate_driven && power_down_n_tristate_level) [*5] |-> ref_internal)
        else $error("high pin did not pick internal reference");
    a_ref_ext: assert property (!power_down_n_tristate_driven [*5] |-> !ref_internal)
        else $error("floating pin did not pick external reference");
    a_shut_idle: assert property (
        shutdown && $past(shutdown) && !$past(th_hold) |-> !th_hold)
        else $error("conversion started in shutdown");
endmodule
bind sac_port sac_port_chk chk_u (.*);
`default_nettype wire

// File: verilog/sac_pkg.sv
package sac_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 8500;
    localparam int ACQ_TIME_NS = 1500;
    localparam int WAKE_TIME_NS = 2000;
    localparam int CYCLE_TIME_NS = 10000;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_CYC = CYCLE_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // Converter shape
    // ----------------------------------------
    localparam int RES_BITS = 12;
    localparam int FRAME_BITS = RES_BITS + 1;
    localparam int STEP_CYC = CONV_CYC / RES_BITS;
    localparam int CNT_W = 8;
    localparam int SYNC_W = 5;
    // Synchroniser reset value matches idle pins (select high, clock low,
    // shutdown pin driven high), so no false select edge follows reset
    localparam logic [SYNC_W-1:0] PIN_IDLE = 5'h16;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    localparam int CTRL_SOFT_SD_BIT = 0;
    localparam logic CTRL_RESET = 1'b0;
    localparam int ST_CONV_BIT = 0;
    localparam int ST_READ_BIT = 1;
    localparam int ST_HOLD_BIT = 2;
    localparam int ST_SHUT_BIT = 3;
    localparam int ST_REFINT_BIT = 4;
    localparam int ST_ACQ_OK_BIT = 5;
    localparam int ST_WAKE_OK_BIT = 6;
    localparam int ST_CS_N_BIT = 7;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SAC_TRACK = 3'b001,
        SAC_CONV = 3'b010,
        SAC_READ = 3'b100
    } sac_mode_e;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic pd_level;
        logic pd_driven;
        logic comp;
    } sac_pins_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sac_apb_req_s;

endpackage

// File: verilog/sac_port.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sac_port
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic power_down_n_tristate_level,
    input wire logic power_down_n_tristate_driven,
    input wire logic comp_in,
    output logic dout_o,
    output logic dout_oe,
    output logic th_hold,
    output logic [RES_BITS-1:0] dac_code,
    output logic shutdown,
    output logic ref_internal,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sac_mode_e mode;
        logic [CNT_W-1:0] tcnt;
        logic [CNT_W-1:0] step;
        logic [3:0] bit_idx;
        logic [RES_BITS-1:0] sar;
        logic [FRAME_BITS-1:0] shreg;
        logic [RES_BITS-1:0] result;
        logic dout;
        logic dout_oe;
        logic th_hold;
        logic [CNT_W-1:0] acq_cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic cs_prev;
        logic sclk_prev;
        logic soft_sd;
        logic shut;
        logic ref_int;
        logic [15:0] conv_count;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sac_state_s;

    sac_state_s s_reg;
    sac_state_s s_next;
    sac_pins_s pins_raw;
    sac_pins_s pins;
    sac_apb_req_s req;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    assign pins_raw.cs_n = cs_n;
    assign pins_raw.sclk = sclk;
    assign pins_raw.pd_level = power_down_n_tristate_level;
    assign pins_raw.pd_driven = power_down_n_tristate_driven;
    assign pins_raw.comp = comp_in;

    sac_sync #(
        .WIDTH(SYNC_W),
        .RST_VAL(PIN_IDLE)
    ) u_sync (
        .clk(ref_clk),
        .rst_n(resetn),
        .d(pins_raw),
        .q(pins)
    );

    assign req.psel = psel;
    assign req.penable = penable;
    assign req.pwrite = pwrite;
    assign req.paddr = paddr;
    assign req.pwdata = pwdata;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == REG_CTRL) || (a == REG_STATUS) ||
            (a == REG_RESULT) || (a == REG_COUNT);
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic [7:0] lim);
        sat_inc = (v >= lim) ? lim : v + 8'h01;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic step_end;
    logic pd_low;
    logic [31:0] status_word;

    always_comb begin
        s_next = s_reg;
        cs_fall = s_reg.cs_prev && !pins.cs_n;
        cs_rise = !s_reg.cs_prev && pins.cs_n;
        sclk_fall = s_reg.sclk_prev && !pins.sclk;
        step_end = (s_reg.step == CNT_W'(STEP_CYC - 1));
        pd_low = pins.pd_driven && !pins.pd_level;
        s_next.cs_prev = pins.cs_n;
        s_next.sclk_prev = pins.sclk;

        s_next.shut = pd_low || s_reg.soft_sd;
        s_next.ref_int = pins.pd_driven && pins.pd_level;

        if (s_reg.shut) begin
            s_next.wake_cnt = '0;
        end else begin
            s_next.wake_cnt = sat_inc(s_reg.wake_cnt, CNT_W'(WAKE_CYC));
        end

        unique case (s_reg.mode)
            SAC_TRACK: begin
                s_next.acq_cnt = sat_inc(s_reg.acq_cnt, CNT_W'(ACQ_CYC));
                if (cs_fall && !s_reg.shut) begin
                    s_next.mode = SAC_CONV;
                    s_next.th_hold = 1'b1;
                    s_next.tcnt = '0;
                    s_next.step = '0;
                    s_next.bit_idx = 4'(RES_BITS - 1);
                    s_next.sar = RES_BITS'(1) << (RES_BITS - 1);
                    s_next.dout = 1'b0;
                end
            end
            SAC_CONV: begin
                s_next.tcnt = s_reg.tcnt + 8'h01;
                s_next.step = step_end ? '0 : s_reg.step + 8'h01;
                if (step_end && s_reg.bit_idx != 4'hf) begin
                    if (!pins.comp) begin
                        s_next.sar[s_reg.bit_idx] = 1'b0;
                    end
                    if (s_reg.bit_idx != 4'h0) begin
                        s_next.sar[s_reg.bit_idx - 4'h1] = 1'b1;
                    end
                    s_next.bit_idx = s_reg.bit_idx - 4'h1;
                end
                if (s_reg.tcnt == CNT_W'(CONV_CYC - 1)) begin
                    s_next.mode = SAC_READ;
                    s_next.th_hold = 1'b0;
                    s_next.acq_cnt = '0;
                    s_next.result = s_reg.sar;
                    s_next.conv_count = s_reg.conv_count + 16'h0001;
                    s_next.shreg = {1'b1, s_reg.sar};
                    s_next.dout = 1'b1;
                end
            end
            SAC_READ: begin
                s_next.acq_cnt = sat_inc(s_reg.acq_cnt, CNT_W'(ACQ_CYC));
                if (sclk_fall) begin
                    s_next.shreg = {s_reg.shreg[FRAME_BITS-2:0], 1'b0};
                    s_next.dout = s_reg.shreg[FRAME_BITS-2];
                end
            end
            default: begin
                s_next.mode = SAC_TRACK;
            end
        endcase

        if (cs_rise) begin
            s_next.mode = SAC_TRACK;
            s_next.th_hold = 1'b0;
            s_next.shreg = '0;
            s_next.dout = 1'b0;
            if (s_reg.mode == SAC_CONV) begin
                s_next.acq_cnt = '0;
            end
        end
        s_next.dout_oe = !pins.cs_n;

        // Register bus: one wait state, answer in second access cycle
        status_word = '0;
        status_word[ST_CONV_BIT] = (s_reg.mode == SAC_CONV);
        status_word[ST_READ_BIT] = (s_reg.mode == SAC_READ);
        status_word[ST_HOLD_BIT] = s_reg.th_hold;
        status_word[ST_SHUT_BIT] = s_reg.shut;
        status_word[ST_REFINT_BIT] = s_reg.ref_int;
        status_word[ST_ACQ_OK_BIT] = (s_reg.acq_cnt == CNT_W'(CYCLE_CYC - CONV_CYC));
        status_word[ST_WAKE_OK_BIT] = (s_reg.wake_cnt == CNT_W'(WAKE_CYC));
        status_word[ST_CS_N_BIT] = pins.cs_n;

        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (req.psel && req.penable && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.pslverr = !reg_hit(req.paddr);
            s_next.prdata = '0;
            if (!req.pwrite) begin
                unique case (req.paddr)
                    REG_CTRL: s_next.prdata[CTRL_SOFT_SD_BIT] = s_reg.soft_sd;
                    REG_STATUS: s_next.prdata = status_word;
                    REG_RESULT: s_next.prdata[RES_BITS-1:0] = s_reg.result;
                    REG_COUNT: s_next.prdata[15:0] = s_reg.conv_count;
                    default: s_next.prdata = '0;
                endcase
            end
        end
        // Write lands on the completing access edge
        if (req.psel && req.penable && s_reg.pready && req.pwrite) begin
            if (req.paddr == REG_CTRL) begin
                s_next.soft_sd = req.pwdata[CTRL_SOFT_SD_BIT];
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.mode <= SAC_TRACK;
            s_reg.cs_prev <= 1'b1;
            s_reg.soft_sd <= CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout_o = s_reg.dout;
    assign dout_oe = s_reg.dout_oe;
    assign th_hold = s_reg.th_hold;
    assign dac_code = s_reg.sar;
    assign shutdown = s_reg.shut;
    assign ref_internal = s_reg.ref_int;
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
endmodule
`default_nettype wire

// File: verilog/sac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sac_sync_s;

    sac_sync_s s_reg;
    sac_sync_s s_next;

    always_comb begin
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= {RST_VAL, RST_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule
`default_nettype wire
